// *** rtl/rsb_slip_status.sv ***
// Receive slip buffer with sticky slip status, interrupt enable and a plain register port.
// Notes on behaviour
// - Empty flag bit 1, sticky, cleared by read.
// - Read when empty replays frame, sets empty.
// - Slip flag bit 0 on underflow or overflow.
// - Write when full, with no read in the same cycle, deletes frame, sets slip.
// - Full flag bit 2 set on frame deletion.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_consts.svh"

module rsb_slip_status
    import rsb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`RSB_ADDR_W-1:0] regAddr,
    input wire rsb_byte_t regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output rsb_byte_t regRdData,
    // Receive stream
    input wire logic rxWrValid,
    input wire rsb_byte_t rxWrData,
    input wire logic rxRdReq,
    output rsb_byte_t rxRdData,
    // Interrupt
    output logic slipIrq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    rsb_flags_t status_reg;
    rsb_flags_t status_next;
    rsb_flags_t enable_reg;
    rsb_flags_t enable_next;
    rsb_flags_t events;
    rsb_level_t fillLevel;
    logic underflowEv;
    logic overflowEv;
    logic statusRead;
    logic enableWrite;

    function automatic rsb_sel_t addrSel(input logic [`RSB_ADDR_W-1:0] addr);
        rsb_sel_t sel;
        sel = RSB_SEL_NONE;
        case (addr)
            `RSB_STATUS_ADDR: begin
                sel = RSB_SEL_STATUS;
            end
            `RSB_ENABLE_ADDR: begin
                sel = RSB_SEL_ENABLE;
            end
            default: begin
                sel = RSB_SEL_NONE;
            end
        endcase
        return sel;
    endfunction : addrSel

    // ----------------------------------------------------------------
    // Elastic store
    // ----------------------------------------------------------------
    rsb_elastic_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wrValid(rxWrValid),
        .wrData(rxWrData),
        .rdReq(rxRdReq),
        .rdData(rxRdData),
        .fillLevel(fillLevel),
        .underflowEv(underflowEv),
        .overflowEv(overflowEv)
    );

    // ----------------------------------------------------------------
    // Sticky status
    // ----------------------------------------------------------------
    assign statusRead = regRdStrobe && (addrSel(regAddr) == RSB_SEL_STATUS);
    assign enableWrite = regWrStrobe && (addrSel(regAddr) == RSB_SEL_ENABLE);

    always_comb begin
        events = '0;
        events[`RSB_EMPTY_BIT] = underflowEv;
        events[`RSB_FULL_BIT] = overflowEv;
        events[`RSB_SLIP_BIT] = underflowEv || overflowEv;
    end

    // The read returns the old flags, so an event in the read cycle must outlive the clear.
    always_comb begin
        status_next = statusRead ? '0 : status_reg;
        status_next = status_next | events;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= `RSB_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ----------------------------------------------------------------
    // Enable register
    // ----------------------------------------------------------------
    assign enable_next = enableWrite ? regWrData[`RSB_FLAG_W-1:0] : enable_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_reg <= `RSB_ENABLE_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else if (regRdStrobe) begin
            case (addrSel(regAddr))
                RSB_SEL_STATUS: begin
                    regRdData <= {{(`RSB_DATA_W-`RSB_FLAG_W){1'b0}}, status_reg};
                end
                RSB_SEL_ENABLE: begin
                    regRdData <= {{(`RSB_DATA_W-`RSB_FLAG_W){1'b0}}, enable_reg};
                end
                default: begin
                    regRdData <= `RSB_UNMAPPED_DATA;
                end
            endcase
        end else begin
            regRdData <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    // Built from next-state values so the output tracks the flags with no extra cycle of lag.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slipIrq <= 1'b0;
        end else begin
            slipIrq <= |(status_next & enable_next);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_underflow;
        underflowEv;
    endsequence

    sequence s_overflow;
        overflowEv;
    endsequence

    sequence s_quiet_read;
        statusRead && !underflowEv && !overflowEv;
    endsequence

    sequence s_event_read;
        statusRead && (underflowEv || overflowEv);
    endsequence

    property p_empty_replay;
        s_underflow |=> status_reg[`RSB_EMPTY_BIT] && status_reg[`RSB_SLIP_BIT]
            && (fillLevel == `RSB_LEVEL_W'(`RSB_FRAME_BYTES - 1 + ($past(rxWrValid) ? 1 : 0)));
    endproperty
    a_empty_replay: assert property (p_empty_replay) else $error("underflow did not replay a frame");

    property p_full_delete;
        s_overflow |=> status_reg[`RSB_FULL_BIT] && status_reg[`RSB_SLIP_BIT]
            && (fillLevel == `RSB_LEVEL_W'(`RSB_DEPTH - `RSB_FRAME_BYTES + 1));
    endproperty
    a_full_delete: assert property (p_full_delete) else $error("overflow did not delete a frame");

    property p_full_only_overflow;
        $rose(status_reg[`RSB_FULL_BIT]) |-> $past(overflowEv);
    endproperty
    a_full_only_overflow: assert property (p_full_only_overflow) else $error("full flag rose without overflow");

    property p_slip_cause;
        $rose(status_reg[`RSB_SLIP_BIT]) |-> $past(underflowEv) || $past(overflowEv);
    endproperty
    a_slip_cause: assert property (p_slip_cause) else $error("slip flag rose without a slip");

    property p_read_clears;
        s_quiet_read ##1 !underflowEv && !overflowEv |=> status_reg == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear flags");

    property p_read_returns;
        statusRead |=> regRdData == {{(`RSB_DATA_W-`RSB_FLAG_W){1'b0}}, $past(status_reg)};
    endproperty
    a_read_returns: assert property (p_read_returns) else $error("status read returned wrong flags");

    property p_sticky;
        status_reg[`RSB_EMPTY_BIT] && !statusRead |=> status_reg[`RSB_EMPTY_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("empty flag dropped without a read");

    property p_coincide_kept;
        s_event_read ##1 statusRead |=> regRdData[`RSB_SLIP_BIT];
    endproperty
    a_coincide_kept: assert property (p_coincide_kept) else $error("event during read was lost");
endmodule : rsb_slip_status
`default_nettype wire

// *** rtl/rsb_consts.svh ***
// Offsets, field positions, reset values and sizes of the receive slip buffer status block.
`ifndef RSB_CONSTS_SVH
`define RSB_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RSB_ADDR_W 16
`define RSB_DATA_W 8
`define RSB_STATUS_ADDR 16'h0B08
`define RSB_ENABLE_ADDR 16'h0B09

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RSB_SLIP_BIT 0
`define RSB_EMPTY_BIT 1
`define RSB_FULL_BIT 2
`define RSB_FLAG_W 3
`define RSB_STATUS_RESET 3'h0
`define RSB_ENABLE_RESET 3'h0
`define RSB_UNMAPPED_DATA 8'h00

// ----------------------------------------------------------------
// Elastic store geometry: two frames of 24 channel bytes
// ----------------------------------------------------------------
`define RSB_FRAME_BYTES 24
`define RSB_DEPTH 48
`define RSB_PTR_W 6
`define RSB_LEVEL_W 6

`endif

// *** rtl/rsb_pkg.sv ***
// Types shared by the receive slip buffer status block.
`include "rsb_consts.svh"

package rsb_pkg;
    typedef logic [`RSB_DATA_W-1:0] rsb_byte_t;
    typedef logic [`RSB_PTR_W-1:0] rsb_ptr_t;
    typedef logic [`RSB_LEVEL_W-1:0] rsb_level_t;
    typedef logic [`RSB_FLAG_W-1:0] rsb_flags_t;
    typedef enum logic [1:0] {
        RSB_SEL_NONE = 2'b00,
        RSB_SEL_STATUS = 2'b01,
        RSB_SEL_ENABLE = 2'b10
    } rsb_sel_t;
endpackage : rsb_pkg

// *** rtl/rsb_elastic_store.sv ***
// Two-frame receive elastic store that repeats a frame on underflow and deletes one on overflow.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_consts.svh"

module rsb_elastic_store
    import rsb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wrValid,
    input wire rsb_byte_t wrData,
    // Read side
    input wire logic rdReq,
    output rsb_byte_t rdData,
    // Status
    output rsb_level_t fillLevel,
    output logic underflowEv,
    output logic overflowEv
);
    rsb_byte_t memory_reg [`RSB_DEPTH];
    rsb_ptr_t wrPtr_reg;
    rsb_ptr_t rdPtr_reg;
    rsb_ptr_t rdBase;
    rsb_ptr_t rdPtr_next;
    rsb_level_t level_reg;
    rsb_level_t level_next;

    function automatic rsb_ptr_t ptrAdd(input rsb_ptr_t ptr, input rsb_ptr_t inc);
        logic [`RSB_PTR_W:0] sum;
        sum = {1'b0, ptr} + {1'b0, inc};
        if (sum >= (`RSB_PTR_W+1)'(`RSB_DEPTH)) begin
            sum = sum - (`RSB_PTR_W+1)'(`RSB_DEPTH);
        end
        return sum[`RSB_PTR_W-1:0];
    endfunction : ptrAdd

    // A write into a full store only counts as overflow when no read frees a slot in the same cycle.
    assign underflowEv = rdReq && (level_reg == '0);
    assign overflowEv = wrValid && !rdReq && (level_reg == `RSB_LEVEL_W'(`RSB_DEPTH));
    assign fillLevel = level_reg;

    always_comb begin
        rdBase = rdPtr_reg;
        level_next = level_reg;
        if (underflowEv) begin
            // Step back one frame so the last frame is played again.
            rdBase = ptrAdd(rdPtr_reg, `RSB_PTR_W'(`RSB_DEPTH - `RSB_FRAME_BYTES));
            level_next = `RSB_LEVEL_W'(`RSB_FRAME_BYTES);
        end else if (overflowEv) begin
            // Skip the oldest frame so the new byte has room.
            rdBase = ptrAdd(rdPtr_reg, `RSB_PTR_W'(`RSB_FRAME_BYTES));
            level_next = `RSB_LEVEL_W'(`RSB_DEPTH - `RSB_FRAME_BYTES);
        end
        rdPtr_next = rdBase;
        if (rdReq) begin
            rdPtr_next = ptrAdd(rdBase, `RSB_PTR_W'(1));
            level_next = level_next - `RSB_LEVEL_W'(1);
        end
        if (wrValid) begin
            level_next = level_next + `RSB_LEVEL_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            level_reg <= '0;
        end else begin
            rdPtr_reg <= rdPtr_next;
            level_reg <= level_next;
            if (wrValid) begin
                wrPtr_reg <= ptrAdd(wrPtr_reg, `RSB_PTR_W'(1));
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < `RSB_DEPTH; i++) begin : g_word
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    memory_reg[i] <= '0;
                end else if (wrValid && (wrPtr_reg == `RSB_PTR_W'(i))) begin
                    memory_reg[i] <= wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData <= '0;
        end else if (rdReq) begin
            rdData <= memory_reg[rdBase];
        end
    end
endmodule : rsb_elastic_store
`default_nettype wire

// *** verification/tb_rsb_slip_status.sv ***
// Self-checking testbench for the receive slip buffer status block.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_rsb_slip_status
    import rsb_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`RSB_ADDR_W-1:0] regAddr = 16'h0000;
    rsb_byte_t regWrData = 8'h00;
    rsb_byte_t rxWrData = 8'h00;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic rxWrValid = 1'b0;
    logic rxRdReq = 1'b0;
    rsb_byte_t regRdData;
    rsb_byte_t rxRdData;
    logic slipIrq;
    rsb_byte_t mem [`RSB_DEPTH];
    rsb_byte_t expRx;
    rsb_byte_t expReg;
    rsb_flags_t flags;
    rsb_flags_t en;
    rsb_flags_t ev;
    logic irqExp;
    logic [31:0] r;
    logic [31:0] r2;
    logic [`RSB_ADDR_W-1:0] a;
    int rp;
    int wp;
    int lvl;
    int failures = 0;
    int comparisons = 0;
    integer seed = 32'h88f2;

    always #5 clk = ~clk;

    rsb_slip_status u_rsb_slip_status (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData), .rxWrValid(rxWrValid), .rxWrData(rxWrData),
        .rxRdReq(rxRdReq), .rxRdData(rxRdData), .slipIrq(slipIrq)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic model_reset();
        for (int i = 0; i < `RSB_DEPTH; i++) mem[i] = 8'h00;
        rp = 0;
        wp = 0;
        lvl = 0;
        flags = 3'h0;
        en = 3'h0;
        expRx = 8'h00;
        expReg = 8'h00;
        irqExp = 1'b0;
    endtask : model_reset

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        {regWrStrobe, regRdStrobe, rxWrValid, rxRdReq} <= 4'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        model_reset();
    endtask : do_reset

    // Drives one cycle of inputs, checks what the previous cycle produced, then advances the model.
    task automatic cyc(input logic wr, input logic rd, input rsb_byte_t d, input logic rs, input logic ws,
                       input logic [`RSB_ADDR_W-1:0] ad, input rsb_byte_t wd);
        logic rdEv;
        logic wrEv;
        @(posedge clk);
        rxWrValid <= wr;
        rxRdReq <= rd;
        rxWrData <= d;
        regRdStrobe <= rs;
        regWrStrobe <= ws;
        regAddr <= ad;
        regWrData <= wd;
        #1;
        `CHK(rxRdData, expRx)
        `CHK(regRdData, expReg)
        `CHK(slipIrq, irqExp)
        rdEv = rd && lvl == 0;
        wrEv = wr && lvl == `RSB_DEPTH && !rd;
        if (rd) begin
            if (rdEv) rp = (rp + `RSB_FRAME_BYTES) % `RSB_DEPTH;
            expRx = mem[rp];
            rp = (rp + 1) % `RSB_DEPTH;
        end
        if (wr) begin
            mem[wp] = d;
            wp = (wp + 1) % `RSB_DEPTH;
            if (wrEv) rp = (rp + `RSB_FRAME_BYTES) % `RSB_DEPTH;
        end
        lvl = rdEv ? `RSB_FRAME_BYTES - 1 + wr : wrEv ? `RSB_DEPTH - `RSB_FRAME_BYTES + 1 : lvl + wr - rd;
        ev = {wrEv, rdEv, rdEv | wrEv};
        expReg = 8'h00;
        if (rs && ad == `RSB_ENABLE_ADDR) expReg = {5'h00, en};
        if (rs && ad == `RSB_STATUS_ADDR) begin
            expReg = {5'h00, flags};
            flags = ev;
        end else begin
            flags = flags | ev;
        end
        if (ws && ad == `RSB_ENABLE_ADDR) en = wd[2:0];
        irqExp = |(flags & en);
    endtask : cyc

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 16'h0000, 8'h00);
    endtask : idle

    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        model_reset();
        do_reset();
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, `RSB_STATUS_ADDR, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, `RSB_ENABLE_ADDR, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 16'h0B0A, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 1'b0, 1'b1, `RSB_ENABLE_ADDR, 8'hFF);
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, `RSB_ENABLE_ADDR, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 1'b0, 1'b1, `RSB_STATUS_ADDR, 8'hFF);
        // Underflow in the very cycle of a status read must survive into the next read.
        cyc(1'b0, 1'b1, 8'h00, 1'b1, 1'b0, `RSB_STATUS_ADDR, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, `RSB_STATUS_ADDR, 8'h00);
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, `RSB_STATUS_ADDR, 8'h00);
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            cyc(1'b1, 1'b0, r[7:0], 1'b0, 1'b0, 16'h0000, 8'h00);
        end
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0, `RSB_STATUS_ADDR, 8'h00);
        for (int i = 0; i < 27; i++) cyc(1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 16'h0000, 8'h00);
        idle(2);
        $display("test directed done");
        for (int p = 0; p < 8; p++) begin
            if (p == 4) begin
                do_reset();
                $display("test mid-run reset done");
            end
            for (int i = 0; i < 250; i++) begin
                r = $random(seed);
                r2 = $random(seed);
                a = r[13:12] == 2'h0 ? `RSB_STATUS_ADDR : r[13:12] == 2'h1 ? `RSB_ENABLE_ADDR :
                    r[13:12] == 2'h2 ? 16'h0B0A : r2[31:16];
                cyc(r[3:0] < ((p % 2) ? 4'h4 : 4'hC), r[7:4] < ((p % 2) ? 4'hC : 4'h4), r2[7:0],
                    r[10:8] == 3'h0 && !r[11], r[10:8] == 3'h0 && r[11], a, r2[15:8]);
            end
        end
        idle(2);
        $display("test random done");
        end_sim();
    end

    // Roughly two and a half times the cycles that the tests need.
    initial begin
        #(5000 * 10);
        failures++;
        end_sim();
    end
endmodule : tb_rsb_slip_status
`default_nettype wire
